// *** logic/flash_pin_ctrl.sv ***
// serial flash pin function control: pause, write protect, lane assignment
`timescale 1ns/1ps
// Overview of operation
// RQ1 - pause low suspends, floats outputs, ignores inputs
// RQ2 - config bit 4 in either register disables pause
// RQ3 - shared pause pin off in quad or DTR
// RQ4 - write-disable plus protect low refuses status write
// RQ5 - protect pin becomes lane two in quad
// RQ6 - single commands: lane zero in, lane one out
// RQ7 - dual commands: lanes zero and one bidirectional
// RQ8 - quad commands: all four lanes bidirectional
// RQ9 - select high: standby, ignore inputs, float outputs; standby_out stays low until busy_r clears
// RQ10 - single edge: sample rising, drive falling; DTR both
// RQ11 - status bit 7 is the write-disable control
// RQ12 - disabled pause leaves transfer running normally
// RQ13 - host always drives protect pin when unused
module flash_pin_ctrl
    import pin_ctrl_pkg::*;
#(
    parameter bit SHARED_PAUSE = 1'b1,
    parameter int WRSR_CNT     = WRSR_CYCLES
) (
    // system
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // serial pins
    input  wire logic        cs_n_in,
    input  wire logic        sclk_in,
    input  wire logic        pause_n_in,
    input  wire logic [3:0]  dq_in,
    output logic      [3:0]  dq_out,
    output logic      [3:0]  dq_oe_out,
    // avalon slave
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // user side
    input  wire logic [7:0]  read_data_in,
    output logic      [23:0] addr_out,
    output logic             addr_valid_out,
    output logic             standby_out,
    output logic             paused_out
);
    logic [7:0]  ctrl_r, nvcfg_r, vcfg_r, status_r;
    logic [23:0] sh_r, sh_nxt;
    logic [7:0]  obuf_r;
    logic [4:0]  cnt_r;
    logic [2:0]  aw_r, dw_r, cw;
    logic        src_sts_r, busy_r;
    logic [15:0] busy_cnt_r;
    logic [3:0]  oe_mask_r;
    eng_state_t  state_r;
    logic        rise, fall, dtr, in_edge, out_edge, pause_en, paused, wp_lvl;
    logic        wrsr_commit;
    logic [1:0]  proto;
    logic [4:0]  cnt_in_nxt;

    sclk_edge sclk_edge_inst (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .sclk_in   (sclk_in),
        .rise_out  (rise),
        .fall_out  (fall)
    );

    // mode decode and pause qualification
    assign proto    = ctrl_r[CTRL_PROTO_LSB +: 2];
    assign dtr      = ctrl_r[CTRL_DTR_BIT];
    assign in_edge  = dtr ? (rise | fall) : rise;                       // RQ10
    assign out_edge = dtr ? (rise | fall) : fall;                       // RQ10
    assign pause_en = nvcfg_r[CFG_PAUSE_BIT] & vcfg_r[CFG_PAUSE_BIT]    // RQ2
                    & ~(SHARED_PAUSE & ((proto == PROTO_QUAD) | dtr | (dw_r == W4))); // RQ3
    assign paused   = pause_en & ~cs_n_in
                    & ~(SHARED_PAUSE ? dq_in[3] : pause_n_in);          // RQ1 RQ12
    assign wp_lvl   = dq_in[2];
    assign cw       = (proto == PROTO_QUAD) ? W4 : (proto == PROTO_DUAL) ? W2 : W1;

    // lane sampling into the shift register
    always_comb begin
        logic [2:0] w;
        w = (state_r == ST_CMD) ? cw : (state_r == ST_ADDR) ? aw_r : dw_r;
        case (w)
            W4:      sh_nxt = {sh_r[19:0], dq_in};                     // RQ8
            W2:      sh_nxt = {sh_r[21:0], dq_in[1:0]};                // RQ7
            default: sh_nxt = {sh_r[22:0], dq_in[0]};                  // RQ6
        endcase
        cnt_in_nxt = cnt_r + {2'h0, w};
    end

    assign wrsr_commit = (state_r == ST_DIN) && in_edge && !paused && !cs_n_in
                       && (cnt_in_nxt == BYTE_BITS);

    // serial engine: command, address, data in, data out
    always_ff @(posedge clk_in) begin
        if (!resetn_in || cs_n_in) begin                                // RQ9
            state_r   <= ST_CMD;
            cnt_r     <= '0;
            sh_r      <= '0;
            aw_r      <= W1;
            dw_r      <= W1;
            src_sts_r <= 1'b0;
            obuf_r    <= '0;
        end else if (!paused) begin                                     // RQ1
            case (state_r)
                ST_CMD: begin
                    if (in_edge) begin
                        sh_r  <= sh_nxt;
                        cnt_r <= cnt_in_nxt;
                        if (cnt_in_nxt == BYTE_BITS) begin
                            cnt_r     <= '0;
                            aw_r      <= cw;
                            dw_r      <= cw;
                            src_sts_r <= 1'b0;
                            case (sh_nxt[7:0])
                                OP_RDSR: begin
                                    state_r   <= ST_DOUT;
                                    src_sts_r <= 1'b1;
                                    obuf_r    <= status_r;
                                end
                                OP_WRSR: state_r <= ST_DIN;
                                OP_READ: state_r <= ST_ADDR;
                                OP_DOFR: begin
                                    state_r <= ST_ADDR;
                                    if (proto == PROTO_EXT) dw_r <= W2;  // RQ7
                                end
                                OP_QUAD_OUTPUT_FAST_READ: begin
                                    state_r <= ST_ADDR;
                                    if (proto == PROTO_EXT) dw_r <= W4;  // RQ5
                                end
                                OP_QUAD_IO_FAST_READ: begin
                                    state_r <= ST_ADDR;
                                    if (proto == PROTO_EXT) begin        // RQ5
                                        aw_r <= W4;
                                        dw_r <= W4;
                                    end
                                end
                                default: state_r <= ST_SKIP;
                            endcase
                        end
                    end
                end
                ST_ADDR: begin
                    if (in_edge) begin
                        sh_r  <= sh_nxt;
                        cnt_r <= cnt_in_nxt;
                        if (cnt_in_nxt == ADDR_BITS) begin
                            cnt_r   <= '0;
                            state_r <= ST_DOUT;
                            obuf_r  <= read_data_in;
                        end
                    end
                end
                ST_DIN: begin
                    if (in_edge) begin
                        sh_r  <= sh_nxt;
                        cnt_r <= cnt_in_nxt;
                        if (cnt_in_nxt == BYTE_BITS) begin
                            state_r <= ST_SKIP;
                        end
                    end
                end
                ST_DOUT: begin
                    if (out_edge) begin
                        obuf_r <= obuf_r << dw_r;
                        cnt_r  <= cnt_r + {2'h0, dw_r};
                        if (cnt_r + {2'h0, dw_r} == BYTE_BITS) begin
                            cnt_r  <= '0;
                            obuf_r <= src_sts_r ? status_r : read_data_in;
                        end
                    end
                end
                ST_SKIP: state_r <= ST_SKIP;
                default: state_r <= ST_CMD;
            endcase
        end
    end

    // output lane drive, data changed only on output edges, lane mask cleared outside data out or on deselect
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            dq_out    <= '0;
            oe_mask_r <= '0;
        end else if (state_r == ST_DOUT && out_edge && !paused && !cs_n_in) begin
            case (dw_r)
                W4: begin
                    dq_out    <= obuf_r[7:4];                           // RQ8
                    oe_mask_r <= OE_W4;                                 // RQ5
                end
                W2: begin
                    dq_out    <= {2'b00, obuf_r[7:6]};                  // RQ7
                    oe_mask_r <= OE_W2;
                end
                default: begin
                    dq_out    <= {2'b00, obuf_r[7], 1'b0};              // RQ6
                    oe_mask_r <= OE_W1;
                end
            endcase
        end else if (state_r != ST_DOUT || cs_n_in) begin
            oe_mask_r <= '0;
        end
    end

    // output enables float during pause or deselect
    always_ff @(posedge clk_in) begin
        if (!resetn_in || cs_n_in || paused) begin                      // RQ1 RQ9
            dq_oe_out <= '0;
        end else if (state_r == ST_DOUT && out_edge) begin
            dq_oe_out <= (dw_r == W4) ? OE_W4 : (dw_r == W2) ? OE_W2 : OE_W1;
        end else begin
            dq_oe_out <= oe_mask_r;
        end
    end

    // captured address for the array side
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            addr_out       <= '0;
            addr_valid_out <= 1'b0;
        end else begin
            addr_valid_out <= 1'b0;
            if (state_r == ST_ADDR && in_edge && !paused && !cs_n_in
                && cnt_in_nxt == ADDR_BITS) begin
                addr_out       <= sh_nxt;
                addr_valid_out <= 1'b1;
            end
        end
    end

    // status register and write cycle timer
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            status_r   <= STATUS_RESET;
            busy_r     <= 1'b0;
            busy_cnt_r <= '0;
        end else begin
            if (busy_r) begin
                busy_cnt_r <= busy_cnt_r - 16'h0001;
                if (busy_cnt_r == 16'h0001) busy_r <= 1'b0;
            end
            if (wrsr_commit && !(status_r[STS_WDIS_BIT] && !wp_lvl)) begin // RQ4 RQ11
                status_r   <= (sh_nxt[7:0] & STS_NV_MASK) | (status_r & ~STS_NV_MASK);
                busy_r     <= 1'b1;
                busy_cnt_r <= WRSR_CNT[15:0];
            end
            status_r[STS_WIP_BIT] <= busy_r;
        end
    end

    // pin level status outputs
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            standby_out <= 1'b1;
            paused_out  <= 1'b0;
        end else begin
            standby_out <= cs_n_in && !busy_r;                         // RQ9
            paused_out  <= paused;
        end
    end

    // avalon slave: one wait cycle, then the answer
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= '0;
            ctrl_r              <= '0;
            nvcfg_r             <= CFG_RESET;
            vcfg_r              <= CFG_RESET;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out) begin
                case (avs_address_in)
                    OFS_CTRL:   avs_readdata_out <= {24'h0, ctrl_r};
                    OFS_NVCFG:  avs_readdata_out <= {24'h0, nvcfg_r};
                    OFS_VCFG:   avs_readdata_out <= {24'h0, vcfg_r};
                    OFS_STATUS: avs_readdata_out <= {24'h0, status_r};
                    OFS_PINS:   avs_readdata_out <= {24'h0, dq_oe_out, pause_en,
                                                     wp_lvl, standby_out, paused_out};
                    default:    avs_readdata_out <= '0;
                endcase
            end
            if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) begin
                case (avs_address_in)
                    OFS_CTRL:  ctrl_r  <= avs_writedata_in[7:0];
                    OFS_NVCFG: nvcfg_r <= avs_writedata_in[7:0];
                    OFS_VCFG:  vcfg_r  <= avs_writedata_in[7:0];
                    default:   ctrl_r  <= ctrl_r;
                endcase
            end
        end
    end

    // checks
    float_deselect_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ9
        cs_n_in |=> dq_oe_out == 4'h0) else $error("outputs driven while deselected");
    pause_float_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ1
        paused |=> dq_oe_out == 4'h0 && $stable(state_r))
        else $error("pause did not suspend");
    pause_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ2
        !(nvcfg_r[CFG_PAUSE_BIT] && vcfg_r[CFG_PAUSE_BIT]) |-> !paused)
        else $error("pause active while disabled");
    shared_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ3
        (SHARED_PAUSE && (proto == PROTO_QUAD || dtr)) |-> !pause_en)
        else $error("shared pause pin still enabled");
    wrsr_block_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ4
        (wrsr_commit && status_r[STS_WDIS_BIT] && !wp_lvl) |=> !busy_r ##0
        $stable(status_r[7:2])) else $error("protected status was written");
    dq2_lane_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ5
        dq_oe_out[2] |-> dw_r == W4) else $error("lane two driven outside quad");
    single_lane_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ6
        (dw_r == W1 && dq_oe_out != 4'h0) |-> dq_oe_out == OE_W1)
        else $error("single mode drove wrong lane");
    dual_lane_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ7
        (dw_r == W2 && dq_oe_out != 4'h0) |-> dq_oe_out == OE_W2)
        else $error("dual mode drove wrong lanes");
    quad_lane_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ8
        (dw_r == W4 && dq_oe_out != 4'h0) |-> dq_oe_out == OE_W4)
        else $error("quad mode missed a lane");
    out_edge_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RQ10
        !out_edge |=> $stable(dq_out)) else $error("output changed off its edge");
    bus_wait_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ((avs_read_in || avs_write_in) && avs_waitrequest_out) |=> !avs_waitrequest_out)
        else $error("bus answer late");
    rdsr_cover_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == ST_DOUT && src_sts_r && dq_oe_out != 4'h0);
    quad_cover_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        dq_oe_out == OE_W4);
    pause_cover_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        paused && state_r == ST_DOUT);
    wrsr_cover_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        wrsr_commit);
endmodule

// *** common/pin_ctrl_pkg.sv ***
// constants for the serial flash pin function control block
package pin_ctrl_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_NVCFG  = 5'h04;
    localparam logic [4:0] OFS_VCFG   = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_PINS   = 5'h10;
    // field positions
    localparam int CTRL_PROTO_LSB = 0;
    localparam int CTRL_DTR_BIT   = 2;
    localparam int CFG_PAUSE_BIT  = 4;
    localparam int STS_WDIS_BIT   = 7;
    localparam int STS_WIP_BIT    = 0;
    // reset values and status write mask
    localparam logic [7:0] CFG_RESET    = 8'hFF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STS_NV_MASK  = 8'hFC;
    // protocol codes
    localparam logic [1:0] PROTO_EXT  = 2'h0;
    localparam logic [1:0] PROTO_DUAL = 2'h1;
    localparam logic [1:0] PROTO_QUAD = 2'h2;
    // opcodes
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_DOFR  = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUTPUT_FAST_READ  = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO_FAST_READ = 8'hEB;
    // lane widths, bit counts and lane enable masks
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [3:0] OE_W1 = 4'h2;
    localparam logic [3:0] OE_W2 = 4'h3;
    localparam logic [3:0] OE_W4 = 4'hF;
    // status write cycle time
    localparam int CLK_PERIOD_NS  = 10;
    localparam int WRSR_TIME_NS   = 1000;
    localparam int WRSR_CYCLES    = (WRSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // serial engine states
    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP} eng_state_t;
endpackage

// *** logic/sclk_edge.sv ***
// edge detector for the host serial clock
`timescale 1ns/1ps
module sclk_edge (
    // system
    input  wire logic clk_in,
    input  wire logic resetn_in,
    // serial clock sample
    input  wire logic sclk_in,
    // edge pulses
    output logic      rise_out,
    output logic      fall_out
);
    logic sclk_q_r;

    // previous level of the serial clock
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk_in;
        end
    end

    // one cycle pulses on each transition
    assign rise_out = sclk_in & ~sclk_q_r;
    assign fall_out = ~sclk_in & sclk_q_r;
endmodule

// *** test/host_model.sv ***
// host serial controller model driving select, clock and the four data lanes
`timescale 1ns/1ps
module host_model (
    // system
    input  wire logic       clk_in,
    // serial pins
    output logic            cs_n_out,
    output logic            sclk_out,
    output logic [3:0]      dq_out,
    output logic [3:0]      dq_oe_out,
    input  wire logic [3:0] dq_in
);
    logic       wp_lvl   = 1'b1;  // write protect level, low = protect
    logic       hold_lvl = 1'b1;  // pause level on lane three
    logic [3:0] own_r    = 4'h0;  // lanes carrying host data
    logic [3:0] rel_r    = 4'h0;  // lanes handed to the device
    logic [3:0] dat_r    = 4'h0;
    // the clock stands low and the device is deselected between frames
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    // lanes two and three keep a defined level unless they carry data
    always_comb begin
        dq_oe_out = (own_r | 4'hD) & ~rel_r;
        dq_out    = (dat_r & own_r) | ({hold_lvl, wp_lvl, 2'b00} & ~own_r);
    end
    // select the device and give it time to wake
    task automatic start();
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    // close the frame and take the lanes back
    task automatic stop();
        @(posedge clk_in);
        sclk_out <= 1'b0;
        cs_n_out <= 1'b1;
        own_r    <= 4'h0;
        rel_r    <= 4'h0;
        repeat (3) @(posedge clk_in);
    endtask
    // launch n steps of w lanes while the clock is low, msb first
    task automatic send(input int w, input int n, input logic [31:0] v);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk_in);
            sclk_out <= 1'b0;
            own_r    <= m;
            rel_r    <= 4'h0;
            dat_r    <= 4'(v >> (i * w)) & m;
            repeat (3) @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask
    // release the lanes and collect what the device shifts out after each fall
    task automatic recv(input int w, input int n, output logic [31:0] r);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        r = 32'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            sclk_out <= 1'b0;
            own_r    <= 4'h0;
            rel_r    <= (w == 1) ? 4'h0 : m;
            repeat (3) @(posedge clk_in);
            r = (r << w) | 32'(((w == 1) ? (dq_in >> 1) : dq_in) & m);
            sclk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule

// *** test/tb_flash_pin_ctrl.sv ***
// self-checking bench for the serial flash pin function control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; $display("[FAIL] %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_flash_pin_ctrl;
    import pin_ctrl_pkg::*;
    localparam int WCNT = 4;
    logic        clk_in    = 1'b0;
    logic        resetn_in = 1'b0;
    logic [4:0]  av_addr   = 5'h00;
    logic        av_rd     = 1'b0;
    logic        av_wr     = 1'b0;
    logic [31:0] av_wdata  = 32'h0;
    logic [7:0]  rd_byte   = 8'h00;
    logic [3:0]  lane_last = 4'h0;
    logic        cs_n, sclk, waitreq, avalid, standby, paused;
    logic [3:0]  h_dq, h_oe, d_dq, d_oe, lanes;
    logic [31:0] rdata, q, q2;
    logic [23:0] addr;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          addr_pulses = 0;
    // clock generator
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // each lane shows its driver, or a drifting level when nobody drives
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lanes[i] = (d_oe[i] === 1'b1) ? d_dq[i]
                     : ((h_oe[i] === 1'b1) ? h_dq[i] : ~lane_last[i]);
        end
    end
    always @(posedge clk_in) lane_last <= lanes;
    // count captured address pulses from the device
    always @(posedge clk_in) if (avalid === 1'b1) addr_pulses <= addr_pulses + 1;
    flash_pin_ctrl #(.SHARED_PAUSE(1'b1), .WRSR_CNT(WCNT)) flash_pin_ctrl_inst (
        .clk_in(clk_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .pause_n_in(1'b1), .dq_in(lanes), .dq_out(d_dq), .dq_oe_out(d_oe),
        .avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
        .avs_writedata_in(av_wdata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .read_data_in(rd_byte), .addr_out(addr),
        .addr_valid_out(avalid), .standby_out(standby), .paused_out(paused));
    host_model host_model_inst (
        .clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .dq_out(h_dq),
        .dq_oe_out(h_oe), .dq_in(lanes));
    // verdict and end of run
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one bus transfer, held until waitrequest is seen low
    task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        @(posedge clk_in);
        av_addr  <= a;
        av_wdata <= d;
        av_rd    <= ~wr;
        av_wr    <= wr;
        for (int n = 0; n <= 20; n++) begin
            if (n == 20) begin
                error_cnt++;
                tally_and_finish();
            end
            @(posedge clk_in);
            if (waitreq === 1'b0) break;
        end
        r = rdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask
    // status write over the serial link, then wait out the write cycle
    task automatic wrsr(input logic [7:0] v);
        host_model_inst.start();
        host_model_inst.send(1, 8, OP_WRSR);
        host_model_inst.send(1, 8, v);
        host_model_inst.stop();
        repeat (WCNT + 4) @(posedge clk_in);
    endtask
    // register reset values, read-only and unmapped places
    task automatic t_reset();
        av_xfer(1'b0, OFS_CTRL, 32'h0, q);
        `CHK(q, 32'h0000_0000);
        av_xfer(1'b0, OFS_NVCFG, 32'h0, q);
        `CHK(q, 32'h0000_00FF);
        av_xfer(1'b0, OFS_VCFG, 32'h0, q);
        `CHK(q, 32'h0000_00FF);
        av_xfer(1'b1, OFS_STATUS, 32'h0000_00FF, q);
        av_xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0000);
        av_xfer(1'b1, 5'h14, 32'h0000_00FF, q);
        av_xfer(1'b0, 5'h14, 32'h0, q);
        `CHK(q, 32'h0000_0000);
        av_xfer(1'b0, OFS_PINS, 32'h0, q);
        `CHK(q, 32'h0000_000E);
    endtask
    // status write, protection by the write-protect lane, single-lane status read
    task automatic t_status();
        wrsr(8'h80);
        av_xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0080);
        host_model_inst.start();
        `CHK(standby, 1'b0);
        host_model_inst.send(1, 8, OP_RDSR);
        host_model_inst.recv(1, 8, q);
        `CHK(q[7:0], 8'h80);
        `CHK(d_oe, OE_W1);
        host_model_inst.stop();
        `CHK(d_oe, 4'h0);
        `CHK(standby, 1'b1);
        @(posedge clk_in);
        host_model_inst.wp_lvl <= 1'b0;
        wrsr(8'h7C);
        av_xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0080);
        @(posedge clk_in);
        host_model_inst.wp_lvl <= 1'b1;
        wrsr(8'h00);
        av_xfer(1'b0, OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0000_0000);
    endtask
    // pause in mid-read, then pause turned off by each config register and by mode
    task automatic t_pause();
        logic [4:0]  ofs[2] = '{OFS_VCFG, OFS_NVCFG};
        logic [31:0] ctl[2] = '{32'h0000_0004, 32'h0000_0002};
        @(posedge clk_in);
        rd_byte <= 8'hA5;
        host_model_inst.start();
        host_model_inst.send(1, 8, OP_READ);
        host_model_inst.send(1, 24, 32'h0012_3456);
        `CHK(addr, 24'h123456);
        host_model_inst.recv(1, 4, q);
        host_model_inst.hold_lvl <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHK(paused, 1'b1);
        `CHK(d_oe, 4'h0);
        host_model_inst.hold_lvl <= 1'b1;
        repeat (4) @(posedge clk_in);
        host_model_inst.recv(1, 4, q2);
        `CHK({q[3:0], q2[3:0]}, 8'hA5);
        host_model_inst.stop();
        for (int k = 0; k < 2; k++) begin
            av_xfer(1'b1, ofs[k], 32'h0000_00EF, q);
            host_model_inst.start();
            host_model_inst.send(1, 8, OP_RDSR);
            host_model_inst.recv(1, 2, q);
            host_model_inst.hold_lvl <= 1'b0;
            repeat (4) @(posedge clk_in);
            `CHK(paused, 1'b0);
            `CHK(d_oe, OE_W1);
            host_model_inst.hold_lvl <= 1'b1;
            host_model_inst.stop();
            av_xfer(1'b1, ofs[k], 32'h0000_00FF, q);
        end
        for (int k = 0; k < 2; k++) begin
            av_xfer(1'b1, OFS_CTRL, ctl[k], q);
            host_model_inst.start();
            host_model_inst.hold_lvl <= 1'b0;
            repeat (4) @(posedge clk_in);
            `CHK(paused, 1'b0);
            host_model_inst.hold_lvl <= 1'b1;
            host_model_inst.stop();
        end
        av_xfer(1'b1, OFS_CTRL, 32'h0, q);
    endtask
    // reads in dual and quad lane widths and every protocol: lane widths, enables, address pulses
    task automatic t_lanes();
        logic [7:0]  ops[5] = '{OP_DOFR, OP_QUAD_OUTPUT_FAST_READ, OP_QUAD_IO_FAST_READ, OP_READ, OP_READ};
        logic [7:0]  dat[5] = '{8'h96, 8'h3C, 8'hC3, 8'h5A, 8'hA5};
        logic [3:0]  oes[5] = '{OE_W2, OE_W4, OE_W4, OE_W2, OE_W4};
        logic [31:0] ctl[5] = '{32'h0, 32'h0, 32'h0, 32'(PROTO_DUAL), 32'(PROTO_QUAD)};
        int          cw[5]  = '{1, 1, 1, 2, 4};
        int          aw[5]  = '{1, 1, 4, 2, 4};
        int          dw[5]  = '{2, 4, 4, 2, 4};
        for (int k = 0; k < 5; k++) begin
            av_xfer(1'b1, OFS_CTRL, ctl[k], q);
            @(posedge clk_in);
            rd_byte <= dat[k];
            host_model_inst.start();
            host_model_inst.send(cw[k], 8 / cw[k], ops[k]);
            host_model_inst.send(aw[k], 24 / aw[k], 32'h00AB_CDE0 | 32'(k));
            `CHK(addr, 24'hABCDE0 | 24'(k));
            host_model_inst.recv(dw[k], 8 / dw[k], q);
            `CHK(q[7:0], dat[k]);
            `CHK(d_oe, oes[k]);
            host_model_inst.stop();
        end
        av_xfer(1'b1, OFS_CTRL, 32'h0, q);
        `CHK(addr_pulses, 6);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_status();
        t_pause();
        t_lanes();
        tally_and_finish();
    end
endmodule
